// *** rtl/auto_reload_pwm_timer.sv ***
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
// How it works
// - Prescaler fed by bus clock or external
// - Ratio field divides by one to 128
// - Run enable low freezes prescaler and counter
// - Force reload bit always reads zero
// - Force reload loads counter, clears prescaler
// - Interrupt when flag set and enabled
// - Flag set on FFh to reload transition
// - Status read clears flag; writes never set
// - Counter readable and writable while running
// - Overflow loads reload value into counter
// - Overflow updates PWM levels by polarity
// - Registers reset to zero
module auto_reload_pwm_timer
(
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [7:0]                        paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              ext_clk,
  output logic      [art_pkg::PWM_CHANNELS-1:0]  pwm_out,
  output logic                                   irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  art_pkg::ctrl_t                      ctrl_q;     // Control fields
  logic                                ovf_q;      // Overflow flag
  logic [7:0]                          count_q;    // Live counter
  logic [7:0]                          reload_q;   // Reload data
  logic [art_pkg::PWM_CHANNELS-1:0]    polarity_q; // Output polarity bits
  logic                                ext_rise;   // Synced external edge
  logic                                src_pulse;  // Selected source pulse
  logic                                tick;       // Counter tick
  logic                                force_ld;   // Force reload strobe
  logic                                overflow;   // Overflow this cycle
  logic                                wr_en;      // Write access phase
  logic                                rd_en;      // Read access phase
  logic                                mapped;     // Address decodes

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Word-aligned register hit
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction

  // Access phase qualifiers, single-cycle answer
  always_comb
  begin
    mapped = is_reg(paddr, art_pkg::OFS_CTRL_STATUS) ||
             is_reg(paddr, art_pkg::OFS_COUNTER) ||
             is_reg(paddr, art_pkg::OFS_RELOAD) ||
             is_reg(paddr, art_pkg::OFS_PWM_CTRL);
    wr_en  = psel && penable && pready && pwrite;
    rd_en  = psel && penable && pready && !pwrite;
  end

  // Ready one cycle after setup, deasserted after access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // ----------------------------------------------------------------
  // Clock source and prescaler
  // ----------------------------------------------------------------
  art_pin_sync u_sync
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_in     (ext_clk),
    .rise_pulse (ext_rise)
  );

  // Bus clock counts every cycle, external clock on its rising edges
  always_comb
  begin
    src_pulse = ctrl_q.clock_source_select ? ext_rise : 1'b1;
    force_ld  = wr_en && is_reg(paddr, art_pkg::OFS_CTRL_STATUS) &&
                pwdata[art_pkg::BIT_FORCE];
    overflow  = tick && (count_q == art_pkg::COUNT_TOP);
  end

  art_prescaler u_pre
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .src_pulse (src_pulse),
    .run       (ctrl_q.counter_run_enable),
    .clear     (force_ld),
    .ratio     (ctrl_q.prescale_ratio_field),
    .tick      (tick)
  );

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Software fields of the control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= '0;
    else if (wr_en && is_reg(paddr, art_pkg::OFS_CTRL_STATUS))
    begin
      ctrl_q.clock_source_select  <= pwdata[art_pkg::BIT_CLK_SEL];
      ctrl_q.prescale_ratio_field <= pwdata[art_pkg::BIT_RATIO_HI:art_pkg::BIT_RATIO_LO];
      ctrl_q.counter_run_enable   <= pwdata[art_pkg::BIT_RUN];
      ctrl_q.overflow_irq_enable  <= pwdata[art_pkg::BIT_OVF_IE];
    end
  end

  // Overflow flag: set wins over read clear, writes ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovf_q <= 1'b0;
    else if (overflow)
      ovf_q <= 1'b1;
    else if (rd_en && is_reg(paddr, art_pkg::OFS_CTRL_STATUS))
      ovf_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Counter and reload
  // ----------------------------------------------------------------
  // Reload data register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reload_q <= art_pkg::RESET_BYTE;
    else if (wr_en && is_reg(paddr, art_pkg::OFS_RELOAD))
      reload_q <= pwdata[7:0];
  end

  // Counter: force, software write, overflow reload, increment
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= art_pkg::RESET_BYTE;
    else if (force_ld)
      count_q <= reload_q;
    else if (wr_en && is_reg(paddr, art_pkg::OFS_COUNTER))
      count_q <= pwdata[7:0];
    else if (overflow)
      count_q <= reload_q;
    else if (tick)
      count_q <= count_q + 8'h01;
  end

  // ----------------------------------------------------------------
  // PWM outputs
  // ----------------------------------------------------------------
  // Polarity bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      polarity_q <= '0;
    else if (wr_en && is_reg(paddr, art_pkg::OFS_PWM_CTRL))
      polarity_q <= pwdata[art_pkg::PWM_CHANNELS-1:0];
  end

  // Output levels take the polarity on each overflow
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm_out <= '0;
    else if (overflow)
      pwm_out <= polarity_q;
  end

  // ----------------------------------------------------------------
  // Interrupt and read data
  // ----------------------------------------------------------------
  // Interrupt level from flag and enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= ovf_q && ctrl_q.overflow_irq_enable;
  end

  // Registered read data, presented with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= '0;
      unique case (1'b1)
        is_reg(paddr, art_pkg::OFS_CTRL_STATUS):
          prdata[7:0] <= {ctrl_q.clock_source_select, ctrl_q.prescale_ratio_field,
                          ctrl_q.counter_run_enable, 1'b0,
                          ctrl_q.overflow_irq_enable, ovf_q};
        is_reg(paddr, art_pkg::OFS_COUNTER):
          prdata[7:0] <= count_q;
        is_reg(paddr, art_pkg::OFS_RELOAD):
          prdata[7:0] <= reload_q;
        is_reg(paddr, art_pkg::OFS_PWM_CTRL):
          prdata[art_pkg::PWM_CHANNELS-1:0] <= polarity_q;
        default:
          prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks: sequences
  // ----------------------------------------------------------------
  // Top reached on a tick, no software load competing
  sequence s_ovf_event;
    tick && (count_q == art_pkg::COUNT_TOP) && !force_ld &&
      !(wr_en && is_reg(paddr, art_pkg::OFS_COUNTER));
  endsequence

  // Setup phase of any transfer
  sequence s_setup;
    psel && !penable;
  endsequence

  // Setup phase of a status read
  sequence s_status_setup;
    psel && !penable && !pwrite && is_reg(paddr, art_pkg::OFS_CTRL_STATUS);
  endsequence

  // ----------------------------------------------------------------
  // Checks: bus answer
  // ----------------------------------------------------------------
  // Ready follows every setup
  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup |=> pready)
    else $error("Ready missing after setup");
  // Ready stands one cycle only
  a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("Ready held too long");
  // Error only for unmapped address
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup |=> pslverr == !$past(mapped))
    else $error("Wrong error response");
  // Upper read bits stay zero
  a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("Upper read bits set");
  // Force bit never read as one
  a_force_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_setup |=> !prdata[art_pkg::BIT_FORCE])
    else $error("Force bit read as one");
  // Status read shows flag before clear
  a_status_flag: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_setup |=> prdata[art_pkg::BIT_OVF] == $past(ovf_q))
    else $error("Flag read back wrong");

  // ----------------------------------------------------------------
  // Checks: flag and interrupt
  // ----------------------------------------------------------------
  // Overflow sets the flag
  a_ovf_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |=> ovf_q)
    else $error("Overflow did not set flag");
  // Completed status read clears the flag
  a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_setup ##1 (rd_en && !overflow) |=> !ovf_q)
    else $error("Read did not clear flag");
  // Writing the flag position never sets it
  a_write_no_set: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && is_reg(paddr, art_pkg::OFS_CTRL_STATUS) && !overflow && !ovf_q |=> !ovf_q)
    else $error("Write set the flag");
  // Enabled flag raises the interrupt
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_q && ctrl_q.overflow_irq_enable |=> irq)
    else $error("Interrupt missing");
  // Disabled interrupt stays low
  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q.overflow_irq_enable |=> !irq)
    else $error("Masked interrupt raised");
  // No interrupt without the flag
  a_irq_needs_flag: assert property (@(posedge pclk) disable iff (!presetn)
    !ovf_q |=> !irq)
    else $error("Interrupt without flag");

  // ----------------------------------------------------------------
  // Checks: counter and prescaler
  // ----------------------------------------------------------------
  // Overflow loads the reload value
  a_reload_on_ovf: assert property (@(posedge pclk) disable iff (!presetn)
    s_ovf_event |=> count_q == $past(reload_q))
    else $error("No reload");
  // Reload register takes written byte
  a_reload_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && is_reg(paddr, art_pkg::OFS_RELOAD) |=> reload_q == $past(pwdata[7:0]))
    else $error("Reload write lost");
  // Force loads the reload value
  a_force_load: assert property (@(posedge pclk) disable iff (!presetn)
    force_ld |=> count_q == $past(reload_q))
    else $error("Force reload failed");
  // Counter takes a written byte
  a_count_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && is_reg(paddr, art_pkg::OFS_COUNTER) |=> count_q == $past(pwdata[7:0]))
    else $error("Counter write lost");
  // Plain tick steps by one
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    tick && !overflow && !wr_en |=> count_q == 8'($past(count_q) + 8'h01))
    else $error("Counter did not step");
  // Stopped counter holds its value
  a_stop_freezes: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q.counter_run_enable && !wr_en |=> $stable(count_q))
    else $error("Frozen counter moved");
  // Stopped prescaler gives no tick
  a_stop_no_tick: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q.counter_run_enable |-> !tick)
    else $error("Tick while stopped");
  // External source ticks only on its edges
  a_ext_only_edges: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q.clock_source_select && !ext_rise |-> !tick)
    else $error("Tick without external edge");
  // Undivided bus clock ticks every cycle
  a_ratio_one: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q.clock_source_select && ctrl_q.prescale_ratio_field == 3'h0 &&
    ctrl_q.counter_run_enable && !force_ld |-> tick)
    else $error("Undivided tick missing");

  // ----------------------------------------------------------------
  // Checks: PWM outputs
  // ----------------------------------------------------------------
  // Overflow applies the polarity bits
  a_pwm_on_ovf: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |=> pwm_out == $past(polarity_q))
    else $error("PWM not updated");
  // Levels hold between overflows
  a_pwm_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !overflow |=> $stable(pwm_out))
    else $error("PWM changed off overflow");

endmodule

// *** rtl/art_pkg.sv ***
package art_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;  // Control and status
  localparam logic [7:0] OFS_COUNTER     = 8'h04;  // Counter access
  localparam logic [7:0] OFS_RELOAD      = 8'h08;  // Reload value
  localparam logic [7:0] OFS_PWM_CTRL    = 8'h0C;  // Output polarity bits

  // ----------------------------------------------------------------
  // Field positions in the control and status register
  // ----------------------------------------------------------------
  localparam int BIT_CLK_SEL   = 7;  // Clock source select
  localparam int BIT_RATIO_HI  = 6;  // Prescale ratio field top
  localparam int BIT_RATIO_LO  = 4;  // Prescale ratio field bottom
  localparam int BIT_RUN       = 3;  // Counter run enable
  localparam int BIT_FORCE     = 2;  // Force reload, write only
  localparam int BIT_OVF_IE    = 1;  // Overflow interrupt enable
  localparam int BIT_OVF       = 0;  // Overflow flag

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int         PWM_CHANNELS = 4;        // Number of PWM outputs
  localparam int         PRESCALE_W   = 7;        // Prescaler width
  localparam logic [7:0] RESET_BYTE   = 8'h00;    // Counter and reload reset value
  localparam logic [7:0] COUNT_TOP    = 8'hFF;    // Overflow point
  localparam int         SYNC_STAGES  = 3;        // Pin synchroniser depth

  // Control fields held as a packed struct
  typedef struct packed {
    logic       clock_source_select;
    logic [2:0] prescale_ratio_field;
    logic       counter_run_enable;
    logic       overflow_irq_enable;
  } ctrl_t;

endpackage

// *** rtl/art_pin_sync.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Three-stage synchroniser with rising edge detect on agreed stages
// ------------------------------------------------------------------
module art_pin_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      rise_pulse
);

  logic [art_pkg::SYNC_STAGES-1:0] sync_q;  // Stage chain
  logic                            level_q; // Last agreed level

  // Shift the pin through the chain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_q <= '0;
    else
      sync_q <= {sync_q[art_pkg::SYNC_STAGES-2:0], pin_in};
  end

  // Level changes once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_q    <= 1'b0;
      rise_pulse <= 1'b0;
    end
    else
    begin
      rise_pulse <= 1'b0;
      if (sync_q[1] == sync_q[2] && sync_q[2] != level_q)
      begin
        level_q    <= sync_q[2];
        rise_pulse <= sync_q[2];
      end
    end
  end

endmodule

// *** rtl/art_prescaler.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Seven-bit prescaler producing a one-cycle counter tick
// ------------------------------------------------------------------
module art_prescaler
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       src_pulse,
  input  wire logic       run,
  input  wire logic       clear,
  input  wire logic [2:0] ratio,
  output logic            tick
);

  logic [art_pkg::PRESCALE_W-1:0] div_q;  // Free count of input pulses

  // Mask of the low bits that must be all ones for a tick
  function automatic logic [art_pkg::PRESCALE_W-1:0] ratio_mask(input logic [2:0] r);
    ratio_mask = 7'((8'h01 << r) - 8'h01);
  endfunction

  // Count source pulses, frozen while stopped, cleared on force
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= '0;
    else if (clear)
      div_q <= '0;
    else if (run && src_pulse)
      div_q <= div_q + 7'h01;
  end

  // Tick when the selected low bits wrap
  always_comb
  begin
    tick = run && src_pulse && !clear &&
           ((div_q & ratio_mask(ratio)) == ratio_mask(ratio));
  end

endmodule

// *** verif/auto_reload_pwm_timer_bench.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Compare macro: counts every check, reports a mismatch at once
// ----------------------------------------------------------------
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end

module auto_reload_pwm_timer_bench;
  // Short names for the register byte addresses
  localparam logic [7:0] CS  = art_pkg::OFS_CTRL_STATUS;
  localparam logic [7:0] CNT = art_pkg::OFS_COUNTER;
  localparam logic [7:0] RLD = art_pkg::OFS_RELOAD;
  localparam logic [7:0] PWM = art_pkg::OFS_PWM_CTRL;

  logic        pclk;        // Bus clock, 100 ns
  logic        presetn;     // Async reset, active low
  logic        psel;        // APB select
  logic        penable;     // APB enable
  logic        pwrite;      // APB direction
  logic [7:0]  paddr;       // APB byte address
  logic [31:0] pwdata;      // APB write data
  logic [31:0] prdata;      // APB read data
  logic        pready;      // APB ready
  logic        pslverr;     // APB error
  logic        ext_clk;     // External count source
  logic [3:0]  pwm_out;     // PWM levels
  logic        irq;         // Interrupt level
  logic [31:0] rd;          // Last read data
  logic        se;          // Last error response
  logic [2:0]  r;           // Ratio code under test
  int          err_total;   // Mismatch count
  int          n_compared;  // Comparison count

  auto_reload_pwm_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk(ext_clk), .pwm_out(pwm_out), .irq(irq));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // One APB transfer; request held until pready seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    `CHK(pready, 1'b1)
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Read and compare against expectation
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  // Bounded wait for the interrupt level
  task automatic wait_irq;
    for (int n = 0; n < 400 && irq !== 1'b1; n++)
      @(negedge pclk);
    `CHK(irq, 1'b1)
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Run needs about 26000 cycles; cut off well beyond that
  initial
  begin
    #6_000_000;
    err_total++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ext_clk = 1'b0;
    err_total = 0;
    n_compared = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and unmapped access
    `CHK({irq, pwm_out}, 5'h00)
    rdchk(CS, 32'h0000_0000);
    rdchk(CNT, 32'h0000_0000);
    rdchk(RLD, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHK({se, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
    done("reset");
    // Force reload while stopped, then frozen
    wr(RLD, 32'h0000_00C3);
    wr(CS, 32'h0000_0004);
    rdchk(CNT, 32'h0000_00C3);
    rdchk(CS, 32'h0000_0000);
    repeat (50) @(posedge pclk);
    rdchk(CNT, 32'h0000_00C3);
    done("force");
    // Every ratio code from the bus clock
    wr(RLD, 32'h0000_0000);
    for (int c = 0; c < 8; c++)
    begin
      r = c[2:0];
      wr(CS, {24'h00_0000, 1'b0, r, 4'hC});
      repeat (100 << c) @(posedge pclk);
      wr(CS, 32'h0000_0000);
      apb(1'b0, CNT, 32'h0000_0000);
      `CHK((rd >= 99) && (rd <= 104), 1'b1)
    end
    done("ratio");
    // External source: twenty slow rising edges
    wr(CS, 32'h0000_008C);
    repeat (20)
    begin
      @(posedge pclk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_clk <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
    wr(CS, 32'h0000_0000);
    rdchk(CNT, 32'h0000_0014);
    done("external");
    // Counter written while running
    wr(CS, 32'h0000_007C);
    wr(CNT, 32'h0000_0010);
    rdchk(CNT, 32'h0000_0010);
    done("live");
    // Masked overflow, then flag write attempt while stopped
    wr(RLD, 32'h0000_00FE);
    wr(CS, 32'h0000_003C);
    repeat (40) @(posedge pclk);
    `CHK(irq, 1'b0)
    rdchk(CS, 32'h0000_0039);
    wr(CS, 32'h0000_0000);
    apb(1'b0, CS, 32'h0000_0000);
    wr(CS, 32'h0000_0001);
    rdchk(CS, 32'h0000_0000);
    done("masked");
    // Enabled overflow: reload, levels, flag clear on read
    wr(PWM, 32'h0000_000A);
    wr(CS, 32'h0000_003E);
    wait_irq();
    rdchk(CNT, 32'h0000_00FE);
    `CHK(pwm_out, 4'hA)
    rdchk(CS, 32'h0000_003B);
    rdchk(CS, 32'h0000_003A);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    wr(PWM, 32'h0000_0005);
    `CHK(pwm_out, 4'hA)
    wait_irq();
    `CHK(pwm_out, 4'h5)
    done("overflow");
    // Reset in mid-run clears registers and outputs
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK({irq, pwm_out}, 5'h00)
    presetn <= 1'b1;
    rdchk(CS, 32'h0000_0000);
    rdchk(CNT, 32'h0000_0000);
    rdchk(RLD, 32'h0000_0000);
    rdchk(PWM, 32'h0000_0000);
    done("midreset");
    stop_test();
  end
endmodule
